// ==== pbsp_array.sv ====
`timescale 1ns/1ns
`include "pbsp_params.svh"

module pbsp_array #(
  parameter int ADDR_W = `PBSP_ADDR_W,
  parameter int DEPTH  = `PBSP_DEPTH,
  parameter int LANES  = `PBSP_LANES,
  parameter int LANE_W = `PBSP_LANE_W
) (
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  input  wire logic                      wr_en,
  input  wire logic [ADDR_W-1:0]         wr_addr,
  input  wire logic [LANES-1:0]          wr_lanes,
  input  wire logic [LANES*LANE_W-1:0]   wr_word,
  input  wire logic                      rd_en,
  input  wire logic [ADDR_W-1:0]         rd_addr,
  output logic      [LANES*LANE_W-1:0]   rd_word
);
  import pbsp_pkg::*;

  logic [LANES*LANE_W-1:0] mem [0:DEPTH-1];
  logic [LANES*LANE_W-1:0] rd_d;
  logic [LANES*LANE_W-1:0] rd_q;

  // ----------------------------------------
  // read with same-edge write forwarding
  // ----------------------------------------
  always_comb begin
    rd_d = rd_q;
    if (rd_en) begin
      rd_d = mem[rd_addr];
      for (int i = 0; i < LANES; i++) begin
        if (wr_en && wr_lanes[i] && wr_addr == rd_addr) begin
          rd_d[i*LANE_W +: LANE_W] = wr_word[i*LANE_W +: LANE_W]; // [R22]
        end
      end
    end
  end

  // ----------------------------------------
  // storage, lane by lane
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < LANES; i++) begin
      if (wr_en && wr_lanes[i]) begin
        mem[wr_addr][i*LANE_W +: LANE_W] <= wr_word[i*LANE_W +: LANE_W]; // [R13] [R25]
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= '0;
    end else begin
      rd_q <= rd_d; // [R21]
    end
  end

  assign rd_word = rd_q;

endmodule

// ==== pbsp_burst_seq.sv ====
`timescale 1ns/1ns
`include "pbsp_params.svh"

module pbsp_burst_seq (
  input  wire logic [`PBSP_SEQ_W-1:0] start,
  input  wire logic [`PBSP_SEQ_W-1:0] step,
  input  wire logic                   interleave,
  output logic      [`PBSP_SEQ_W-1:0] idx
);
  import pbsp_pkg::*;

  // ----------------------------------------
  // low address bits of a burst beat
  // ----------------------------------------
  function automatic logic [`PBSP_SEQ_W-1:0] seq_bits(
    input logic [`PBSP_SEQ_W-1:0] s,
    input logic [`PBSP_SEQ_W-1:0] n,
    input logic                   il
  );
    logic [`PBSP_SEQ_W-1:0] r;
    if (il) begin
      r = s ^ n; // [R24]
    end else begin
      r = `PBSP_SEQ_W'(s + n); // [R24]
    end
    return r;
  endfunction

  always_comb begin
    idx = seq_bits(start, step, interleave);
  end

endmodule

// ==== pbsp_ctl_model.sv ====
`timescale 1ns/1ns
module pbsp_ctl_model (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        en,
  input  wire logic        wbeat,
  output logic      [35:0] dq
);
  logic [1:0] pend_q;
  logic [7:0] n_q;
  // --------
  // write data slot
  // --------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= 2'h0;
      n_q <= 8'h00;
      dq <= 36'h000000000;
    end else if (en) begin
      pend_q <= {pend_q[0], wbeat};
      if (pend_q[0]) begin
        dq <= {n_q[3:0], {4{n_q}}};
        n_q <= n_q + 8'h01;
      end else begin
        dq <= ~dq;
      end
    end else if (!pend_q[1]) begin
      dq <= ~dq;
    end
  end
endmodule

// ==== pbsp_params.svh ====
`ifndef PBSP_PARAMS_SVH
`define PBSP_PARAMS_SVH

// ----------------------------------------
// geometry
// ----------------------------------------
`define PBSP_ADDR_W    17
`define PBSP_DEPTH     131072
`define PBSP_LANES     4
`define PBSP_LANE_W    9
`define PBSP_BYTE_W    8
`define PBSP_DATA_W    32
`define PBSP_WORD_W    36
`define PBSP_SEQ_W     2

// ----------------------------------------
// timing counts, in clock cycles
// ----------------------------------------
`define PBSP_DATA_LAT  2
`define PBSP_BURST_LEN 4

// ----------------------------------------
// reset values
// ----------------------------------------
`define PBSP_RST_ADDR  17'h00000
`define PBSP_RST_LANES 4'h0
`define PBSP_RST_CNT   2'h0
`define PBSP_RST_WORD  36'h000000000

`endif

// ==== pbsp_pkg.sv ====
`include "pbsp_params.svh"

package pbsp_pkg;

  // ----------------------------------------
  // burst state
  // ----------------------------------------
  typedef enum logic [2:0] {
    PBSP_IDLE     = 3'b001,
    PBSP_BURST_RD = 3'b010,
    PBSP_BURST_WR = 3'b100
  } pbsp_mode_t;

  // ----------------------------------------
  // one pipeline stage
  // ----------------------------------------
  typedef struct packed {
    logic                        valid;
    logic                        write;
    logic [`PBSP_ADDR_W-1:0]     addr;
    logic [`PBSP_LANES-1:0]      lanes;
  } pbsp_stage_t;

  // ----------------------------------------
  // port state outside the array and its read register
  // ----------------------------------------
  typedef struct packed {
    pbsp_mode_t                  mode;
    logic [`PBSP_ADDR_W-1:0]     base;
    logic [`PBSP_SEQ_W-1:0]      cnt;
    pbsp_stage_t                 s1;
    pbsp_stage_t                 s2;
    pbsp_stage_t                 s3;
    logic                        drive;
  } pbsp_state_t;

  typedef struct packed {
    logic [`PBSP_WORD_W-1:0]     word;
  } pbsp_rd_state_t;

endpackage

// ==== pbsp_port.sv ====
`timescale 1ns/1ns
`include "pbsp_params.svh"

// Notes on behaviour
// R1: 128K words of 36 bits, 17-bit address
// R2: data moves two cycles after command
// R3: clk_gate_n high freezes everything that edge
// R4: address captured only on selected load edge
// R5: selected load starts a fresh access
// R6: deselected load ends burst, no operation
// R7: pending pipeline transfers still complete
// R8: advance steps counter, ignores address pins
// R9: read_not_write high reads, low writes
// R10: select needs sel_n_a, sel_n_b low, sel_p high
// R11: data lines float two cycles after deselect
// R12: data lines float two cycles after write
// R13: per-lane byte_wr_n, written two cycles later
// R14: controller drives byte_wr_n each write beat
// R15: byte_wr_n ignored on read commands
// R16: controller may tie byte_wr_n low
// R17: four beats per loaded address
// R18: linear_order_sel high interleaved, low linear
// R19: out_en_n high floats data asynchronously
// R20: sleep_req gates clock, keeps data
// R21: write and read data registered on edge
// R22: reads and writes back to back
// R23: burst keeps type of its load
// R24: counter changes low two bits, wraps
// R25: lanes are bytes with their parity bits
// R26: data lines float after first edge
module pbsp_port #(
  parameter int ADDR_W = `PBSP_ADDR_W,
  parameter int DEPTH  = `PBSP_DEPTH
) (
  input  wire logic                        ref_clk,
  input  wire logic                        rst_n,
  input  wire logic                        clk_gate_n,
  input  wire logic                        advance_or_load,
  input  wire logic                        read_not_write,
  input  wire logic                        sel_n_a,
  input  wire logic                        sel_n_b,
  input  wire logic                        sel_p,
  input  wire logic [`PBSP_ADDR_W-1:0]     addr_pins,
  input  wire logic [`PBSP_LANES-1:0]      byte_wr_n,
  input  wire logic                        linear_order_sel,
  input  wire logic                        out_en_n,
  input  wire logic                        sleep_req,
  input  wire logic [`PBSP_DATA_W-1:0]     data_lines_in,
  input  wire logic [`PBSP_LANES-1:0]      parity_lines_in,
  output logic      [`PBSP_DATA_W-1:0]     data_lines_out,
  output logic      [`PBSP_LANES-1:0]      parity_lines_out,
  output logic                             data_lines_oe
);
  import pbsp_pkg::*;

  pbsp_state_t             st_q;
  pbsp_state_t             st_d;
  logic                    hold;
  logic                    selected;
  logic [`PBSP_SEQ_W-1:0]  next_cnt;
  logic [`PBSP_SEQ_W-1:0]  beat_bits;
  logic [`PBSP_WORD_W-1:0] wr_word;
  logic [`PBSP_WORD_W-1:0] rd_word;
  logic                    arr_wr_en;
  logic                    arr_rd_en;

  // ----------------------------------------
  // input qualifiers
  // ----------------------------------------
  assign hold     = clk_gate_n | sleep_req; // [R3] [R20]
  assign selected = ~sel_n_a & ~sel_n_b & sel_p; // [R10]
  assign next_cnt = `PBSP_SEQ_W'(st_q.cnt + 2'h1);

  // ----------------------------------------
  // burst sequence
  // ----------------------------------------
  pbsp_burst_seq u_seq (
    .start      (st_q.base[`PBSP_SEQ_W-1:0]),
    .step       (next_cnt),
    .interleave (linear_order_sel), // [R18]
    .idx        (beat_bits)
  );

  // ----------------------------------------
  // lane packing, parity on top of each byte
  // ----------------------------------------
  always_comb begin
    wr_word = '0;
    for (int i = 0; i < `PBSP_LANES; i++) begin
      wr_word[i*`PBSP_LANE_W +: `PBSP_LANE_W] =
        {parity_lines_in[i], data_lines_in[i*`PBSP_BYTE_W +: `PBSP_BYTE_W]}; // [R25]
    end
  end

  always_comb begin
    data_lines_out   = '0;
    parity_lines_out = '0;
    for (int i = 0; i < `PBSP_LANES; i++) begin
      data_lines_out[i*`PBSP_BYTE_W +: `PBSP_BYTE_W] =
        rd_word[i*`PBSP_LANE_W +: `PBSP_BYTE_W];
      parity_lines_out[i] = rd_word[i*`PBSP_LANE_W + `PBSP_BYTE_W];
    end
  end

  // ----------------------------------------
  // command decode and pipeline
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    if (!hold) begin
      st_d.s1.valid = 1'b0;
      st_d.s1.write = 1'b0;
      st_d.s1.lanes = `PBSP_RST_LANES;
      if (!advance_or_load) begin
        if (selected) begin
          st_d.base     = addr_pins; // [R4]
          st_d.cnt      = `PBSP_RST_CNT; // [R5]
          st_d.s1.valid = 1'b1;
          st_d.s1.addr  = addr_pins;
          st_d.s1.write = ~read_not_write; // [R9]
          st_d.mode     = read_not_write ? PBSP_BURST_RD : PBSP_BURST_WR;
          if (!read_not_write) begin
            st_d.s1.lanes = ~byte_wr_n; // [R13]
          end // [R15] lanes stay clear on reads
        end else begin
          st_d.mode = PBSP_IDLE; // [R6]
        end
      end else begin
        case (st_q.mode)
          PBSP_BURST_RD: begin
            st_d.cnt      = next_cnt; // [R8] [R17]
            st_d.s1.valid = 1'b1;
            st_d.s1.write = 1'b0; // [R23]
            st_d.s1.addr  = {st_q.base[`PBSP_ADDR_W-1:`PBSP_SEQ_W], beat_bits}; // [R24]
          end
          PBSP_BURST_WR: begin
            st_d.cnt      = next_cnt; // [R8] [R17]
            st_d.s1.valid = 1'b1;
            st_d.s1.write = 1'b1; // [R23]
            st_d.s1.addr  = {st_q.base[`PBSP_ADDR_W-1:`PBSP_SEQ_W], beat_bits}; // [R24]
            st_d.s1.lanes = ~byte_wr_n; // [R14] [R13]
          end
          PBSP_IDLE: begin
            st_d.mode = PBSP_IDLE;
          end
          default: begin
            st_d.mode = PBSP_IDLE;
          end
        endcase
      end
      st_d.s2    = st_q.s1; // [R7] [R2]
      st_d.s3    = st_q.s2; // [R7]
      st_d.drive = st_q.s2.valid & ~st_q.s2.write; // [R11] [R12] [R2]
    end
  end

  // ----------------------------------------
  // array access at the data slot
  // ----------------------------------------
  assign arr_wr_en = ~hold & st_q.s3.valid & st_q.s3.write; // [R21] [R2]
  assign arr_rd_en = ~hold & st_q.s2.valid & ~st_q.s2.write; // [R2] [R22]

  pbsp_array #(
    .ADDR_W (ADDR_W),
    .DEPTH  (DEPTH)
  ) u_array (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .wr_en    (arr_wr_en),
    .wr_addr  (st_q.s3.addr[ADDR_W-1:0]), // [R1]
    .wr_lanes (st_q.s3.lanes),
    .wr_word  (wr_word),
    .rd_en    (arr_rd_en),
    .rd_addr  (st_q.s2.addr[ADDR_W-1:0]), // [R1]
    .rd_word  (rd_word)
  );

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q.mode  <= PBSP_IDLE;
      st_q.base  <= `PBSP_RST_ADDR;
      st_q.cnt   <= `PBSP_RST_CNT;
      st_q.s1    <= '0;
      st_q.s2    <= '0;
      st_q.s3    <= '0;
      st_q.drive <= 1'b0; // [R26]
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------
  // asynchronous output gate
  // ----------------------------------------
  assign data_lines_oe = st_q.drive & ~out_en_n; // [R19]

endmodule

// ==== pbsp_port_sva.sv ====
`timescale 1ns/1ns
`include "pbsp_params.svh"
module pbsp_port_sva #(
  parameter int ADDR_W = `PBSP_ADDR_W,
  parameter int DEPTH  = `PBSP_DEPTH
) (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        clk_gate_n,
  input wire logic        advance_or_load,
  input wire logic        read_not_write,
  input wire logic        sel_n_a,
  input wire logic        sel_n_b,
  input wire logic        sel_p,
  input wire logic        out_en_n,
  input wire logic        sleep_req,
  input wire logic [31:0] data_lines_out,
  input wire logic        data_lines_oe
);
  logic en, sel, ld_rd, ld_wr, dsl;
  assign en = !clk_gate_n && !sleep_req;
  assign sel = !sel_n_a && !sel_n_b && sel_p;
  assign ld_rd = en && !advance_or_load && sel && read_not_write;
  assign ld_wr = en && !advance_or_load && sel && !read_not_write;
  assign dsl = en && !advance_or_load && !sel;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  a_gate_hold: assert property (clk_gate_n |=> $stable(data_lines_out))
    else $error("data moved on gated edge");
  a_sleep_hold: assert property (sleep_req |=> $stable(data_lines_out))
    else $error("data moved in sleep");
  a_oe_async: assert property (out_en_n |-> !data_lines_oe)
    else $error("drive with enable off");
  a_read_drive: assert property (
    ld_rd ##1 en ##1 en |=> data_lines_oe == !out_en_n)
    else $error("read slot wrong");
  a_write_float: assert property (ld_wr ##1 en ##1 en |=> !data_lines_oe)
    else $error("drive in write slot");
  a_dsel_float: assert property (dsl ##1 en ##1 en |=> !data_lines_oe)
    else $error("drive after deselect");
  a_pending_done: assert property (
    ld_rd ##1 (en && advance_or_load) ##1 dsl ##1 en |=> data_lines_oe == !out_en_n)
    else $error("pending read lost");
  a_burst_read: assert property (
    ld_rd ##1 (en && advance_or_load) ##1 en ##1 en |=> data_lines_oe == !out_en_n)
    else $error("burst read slot wrong");
  c_burst: cover property (ld_rd ##1 (en && advance_or_load));
  c_dsel: cover property (ld_rd ##1 en ##1 dsl);
  c_gate: cover property (clk_gate_n ##1 en);
endmodule
bind pbsp_port pbsp_port_sva #(.ADDR_W(ADDR_W), .DEPTH(DEPTH)) u_sva (
  .ref_clk, .rst_n, .clk_gate_n, .advance_or_load, .read_not_write, .sel_n_a,
  .sel_n_b, .sel_p, .out_en_n, .sleep_req, .data_lines_out, .data_lines_oe
);

// ==== tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
  logic        ref_clk, rst_n, clk_gate_n, advance_or_load, read_not_write;
  logic        sel_n_a, sel_n_b, sel_p, linear_order_sel, out_en_n, sleep_req;
  logic [16:0] addr_pins;
  logic [3:0]  byte_wr_n, parity_lines_in, parity_lines_out;
  logic [31:0] data_lines_in, data_lines_out;
  logic        data_lines_oe, en, wq, op, rdb;
  logic [35:0] dq, mem [0:1023];
  logic [15:0] s1, s2, s3, b;
  logic [9:0]  base;
  logic [1:0]  cnt;
  int          bad_count = 0, tests_run = 0, cyc = 0;
  pbsp_port #(.ADDR_W(10), .DEPTH(1024)) u_dut (
    .ref_clk, .rst_n, .clk_gate_n, .advance_or_load, .read_not_write, .sel_n_a,
    .sel_n_b, .sel_p, .addr_pins, .byte_wr_n, .linear_order_sel, .out_en_n,
    .sleep_req, .data_lines_in, .parity_lines_in, .data_lines_out,
    .parity_lines_out, .data_lines_oe
  );
  pbsp_ctl_model u_ctl (.ref_clk, .rst_n, .en, .wbeat(wq), .dq);
  assign en = !clk_gate_n && !sleep_req;
  assign {parity_lines_in, data_lines_in} = dq;
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // --------
  // reference model
  // --------
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      {s1, s2, s3, op} = '0;
      wq <= 1'b0;
    end else if (en) begin
      for (int i = 0; i < 4; i++) begin
        if (s3[15] && !s3[14] && !s3[10+i]) begin
          mem[s3[9:0]][8*i +: 8] = dq[8*i +: 8];
          mem[s3[9:0]][32+i] = dq[32+i];
        end
      end
      if (!advance_or_load) begin
        op = !sel_n_a && !sel_n_b && sel_p;
        rdb = read_not_write;
        base = addr_pins[9:0];
        cnt = 2'h0;
      end else begin
        cnt = cnt + 2'h1;
      end
      b[1:0] = linear_order_sel ? base[1:0] ^ cnt : base[1:0] + cnt;
      b[15:2] = {op, rdb, byte_wr_n, base[9:2]};
      {s3, s2, s1} = {s2, s1, b};
      wq <= op && !rdb;
    end
    #2;
    if (rst_n) begin
      check(data_lines_oe, s3[15] && s3[14] && !out_en_n);
      if (s3[15] && s3[14] && !out_en_n) begin
        check({parity_lines_out, data_lines_out}, mem[s3[9:0]]);
      end
    end
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic adv, rnw, input logic [2:0] s, input logic [9:0] a,
                     input logic [3:0] bw);
    @(posedge ref_clk);
    advance_or_load <= adv;
    read_not_write <= rnw;
    {sel_n_a, sel_n_b, sel_p} <= s;
    addr_pins <= {7'h00, a};
    byte_wr_n <= bw;
  endtask
  task automatic idle(input int n);
    repeat (n) cmd(1'b0, 1'b1, 3'b000, 10'h000, 4'hF);
  endtask
  // --------
  // scenarios
  // --------
  task automatic s_bursts();
    for (int l = 0; l < 2; l++) begin
      linear_order_sel <= l[0];
      cmd(1'b0, 1'b0, 3'b001, 10'h0D2 | 10'(l << 2), 4'h0);
      repeat (3) cmd(1'b1, 1'b1, 3'b001, 10'h3FF, 4'h0);
      cmd(1'b0, 1'b1, 3'b001, 10'h0D2 | 10'(l << 2), 4'h5);
      repeat (5) cmd(1'b1, 1'b0, 3'b001, 10'h000, 4'h0);
      idle(4);
    end
  endtask
  task automatic s_lanes();
    cmd(1'b0, 1'b0, 3'b001, 10'h040, 4'h0);
    for (int i = 0; i < 5; i++) begin
      cmd(1'b0, 1'b0, 3'b001, 10'h040, ~(4'h1 << i));
      cmd(1'b0, 1'b1, 3'b001, 10'h040, 4'h0);
    end
    idle(4);
  endtask
  task automatic s_deselect();
    for (int j = 0; j < 3; j++) begin
      cmd(1'b0, 1'b1, 3'b001, 10'h0D1, 4'hF);
      cmd(1'b1, 1'b1, 3'b001, 10'h000, 4'hF);
      cmd(1'b0, 1'b1, (j == 0) ? 3'b101 : (j == 1) ? 3'b011 : 3'b000, 10'h0D5, 4'hF);
      repeat (3) cmd(1'b1, 1'b1, 3'b001, 10'h0D5, 4'hF);
    end
  endtask
  task automatic s_suspend();
    cmd(1'b0, 1'b1, 3'b001, 10'h0D4, 4'hF);
    cmd(1'b1, 1'b1, 3'b001, 10'h000, 4'hF);
    @(posedge ref_clk);
    clk_gate_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    clk_gate_n <= 1'b0;
    sleep_req <= 1'b1;
    @(posedge ref_clk);
    sleep_req <= 1'b0;
    out_en_n <= 1'b1;
    @(posedge ref_clk);
    out_en_n <= 1'b0;
    idle(4);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    {rst_n, clk_gate_n, advance_or_load, sel_n_a, sel_n_b, sel_p} = 6'h00;
    {read_not_write, linear_order_sel, out_en_n, sleep_req} = 4'h8;
    addr_pins = 17'h00000;
    byte_wr_n = 4'hF;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    s_bursts();
    s_lanes();
    s_deselect();
    s_suspend();
    report_and_stop();
  end
endmodule
